// [hw/cmp1_ctrl.sv]
// Control and status registers of comparator one
//
// Function
// - Control bit 7 powers the comparator up when 1, down when 0.
// - Control bit 6 reads 1 while positive input exceeds negative input.
// - Control bit 5 sets on rising output, holds until software writes 0.
// - Control bit 4 sets on falling output, holds until software clears it.
// - Control bits 3-2 select positive hysteresis code, driven to analog core.
// - Control bits 1-0 select negative hysteresis with the same four codes.
// - Control register at 0x9A, resets to zero, bit 6 read-only.
// - Input select bits 7-6 and 3-2 ignore writes, read as ones.
// - Input select bits 5-4 choose the negative input pin.
// - Input select bits 1-0 choose the positive input pin.
// - Input select register at 0x9E, resets to all ones.
// - Mode bit 5 enables the rising-edge interrupt request.
// - Mode bit 4 enables the falling-edge interrupt request.
// - Mode bits 1-0 select one of four response times.
// - Mode bits 7-6 and 3-2 read zero and ignore writes.
// - Mode register at 0x9C, resets to response mode 2, enables clear.
// - Interrupts can be raised on both edges, each with its own enable.
// - Output routed to a pin reads low while comparator is disabled.
`timescale 1ns/100ps
module cmp1_ctrl
	import cmp1_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	// Special-function register access
	input  wire cmp1_sfr_req_t     sfr_req_i,
	output logic [7:0]             sfr_rdata_o,
	output logic                   sfr_hit_o,
	// Analog core
	input  wire logic              comparator_raw_i,
	output cmp1_analog_cfg_t       analog_cfg_o,
	// Pin output and interrupt
	output logic                   pin_output_o,
	output logic                   irq_o
);

	// ********************************************************************
	// Register state
	// ********************************************************************
	logic       comparator_power_on;
	logic       rising_edge_flag;
	logic       falling_edge_flag;
	cmp1_hyst_t positive_hysteresis_field;
	cmp1_hyst_t negative_hysteresis_field;
	logic [1:0] negative_input_select;
	logic [1:0] positive_input_select;
	logic       rising_edge_irq_enable;
	logic       falling_edge_irq_enable;
	cmp1_resp_t response_time_select;

	// ********************************************************************
	// Address decode
	// ********************************************************************
	wire hit_control = (sfr_req_i.addr == CMP1_CONTROL_ADDR);
	wire hit_mode    = (sfr_req_i.addr == CMP1_MODE_ADDR);
	wire hit_select  = (sfr_req_i.addr == CMP1_INPUT_SELECT_ADDR);
	wire wr_control  = sfr_req_i.wr & hit_control;
	wire wr_mode     = sfr_req_i.wr & hit_mode;
	wire wr_select   = sfr_req_i.wr & hit_select;
	wire [7:0] wd    = sfr_req_i.wdata;

	// ********************************************************************
	// Comparator output synchronisation
	// ********************************************************************
	logic out_level;
	logic out_rise;
	logic out_fall;

	cmp1_edge_sync u_sync (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    (comparator_raw_i),
		.level_o    (out_level),
		.rise_o     (out_rise),
		.fall_o     (out_fall)
	);

	// A powered-down core may float, so its output counts as low
	wire out_state  = out_level & comparator_power_on;
	wire edge_rise  = out_rise & comparator_power_on;
	wire edge_fall  = out_fall & comparator_power_on;

	// ********************************************************************
	// Flags: an edge in the clearing cycle wins over the write
	// ********************************************************************
	wire next_rising_edge_flag  = edge_rise |
		(wr_control ? wd[CMP1_RISE_FLAG_BIT] : rising_edge_flag);
	wire next_falling_edge_flag = edge_fall |
		(wr_control ? wd[CMP1_FALL_FLAG_BIT] : falling_edge_flag);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rising_edge_flag  <= CMP1_CONTROL_RESET[CMP1_RISE_FLAG_BIT];
			falling_edge_flag <= CMP1_CONTROL_RESET[CMP1_FALL_FLAG_BIT];
		end else begin
			rising_edge_flag  <= next_rising_edge_flag;
			falling_edge_flag <= next_falling_edge_flag;
		end
	end

	// ********************************************************************
	// Control register
	// ********************************************************************
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			comparator_power_on       <= CMP1_CONTROL_RESET[CMP1_POWER_ON_BIT];
			positive_hysteresis_field <= cmp1_hyst_t'(CMP1_CONTROL_RESET[3:2]);
			negative_hysteresis_field <= cmp1_hyst_t'(CMP1_CONTROL_RESET[1:0]);
		end else if (wr_control) begin
			comparator_power_on       <= wd[CMP1_POWER_ON_BIT];
			positive_hysteresis_field <= cmp1_hyst_t'(wd[CMP1_HYST_POS_LSB +: 2]);
			negative_hysteresis_field <= cmp1_hyst_t'(wd[CMP1_HYST_NEG_LSB +: 2]);
		end
	end

	// ********************************************************************
	// Mode register
	// ********************************************************************
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rising_edge_irq_enable  <= CMP1_MODE_RESET[CMP1_RISE_IE_BIT];
			falling_edge_irq_enable <= CMP1_MODE_RESET[CMP1_FALL_IE_BIT];
			response_time_select    <= cmp1_resp_t'(CMP1_MODE_RESET[1:0]);
		end else if (wr_mode) begin
			rising_edge_irq_enable  <= wd[CMP1_RISE_IE_BIT];
			falling_edge_irq_enable <= wd[CMP1_FALL_IE_BIT];
			response_time_select    <= cmp1_resp_t'(wd[CMP1_RESP_LSB +: 2]);
		end
	end

	// ********************************************************************
	// Input select register
	// ********************************************************************
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			negative_input_select <= CMP1_INPUT_SELECT_RESET[5:4];
			positive_input_select <= CMP1_INPUT_SELECT_RESET[1:0];
		end else if (wr_select) begin
			negative_input_select <= wd[CMP1_NEG_SEL_LSB +: 2];
			positive_input_select <= wd[CMP1_POS_SEL_LSB +: 2];
		end
	end

	// ********************************************************************
	// Read data
	// ********************************************************************
	wire [7:0] control_view = {comparator_power_on, out_state, rising_edge_flag,
		falling_edge_flag, positive_hysteresis_field, negative_hysteresis_field};
	wire [7:0] mode_view = {CMP1_MODE_UNUSED, rising_edge_irq_enable,
		falling_edge_irq_enable, CMP1_MODE_UNUSED, response_time_select};
	wire [7:0] select_view = {CMP1_SELECT_UNUSED, negative_input_select,
		CMP1_SELECT_UNUSED, positive_input_select};

	// Unmapped addresses return zero and leave the hit low so other blocks can answer
	wire [7:0] next_rdata = hit_control ? control_view :
		hit_mode ? mode_view :
		hit_select ? select_view : 8'h00;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_req_i.rd) begin
			sfr_rdata_o <= next_rdata;
		end
	end

	assign sfr_hit_o = hit_control | hit_mode | hit_select;

	// ********************************************************************
	// Outputs to the core, pin and interrupt controller
	// ********************************************************************
	assign analog_cfg_o.comparator_power_on       = comparator_power_on;
	assign analog_cfg_o.positive_hysteresis_field = positive_hysteresis_field;
	assign analog_cfg_o.negative_hysteresis_field = negative_hysteresis_field;
	assign analog_cfg_o.response_time_select      = response_time_select;
	assign analog_cfg_o.positive_input_select     = positive_input_select;
	assign analog_cfg_o.negative_input_select     = negative_input_select;

	assign pin_output_o = out_state;

	// Spurious edges after power-up or mode change are left for software to clear
	assign irq_o = (rising_edge_flag & rising_edge_irq_enable) |
		(falling_edge_flag & falling_edge_irq_enable);

endmodule : cmp1_ctrl

// [hw/cmp1_edge_sync.sv]
// Two-stage synchroniser and edge detector for the raw comparator output
`timescale 1ns/100ps
module cmp1_edge_sync
	import cmp1_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	// Asynchronous level in
	input  wire logic async_i,
	// Synchronised level and edges
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	logic meta;
	logic sync;
	logic prev;

	// First stage feeds only the second, so no logic sees a metastable value
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= async_i;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level_o = sync;
	assign rise_o  = sync & ~prev;
	assign fall_o  = ~sync & prev;

endmodule : cmp1_edge_sync

// [hw/cmp1_pkg.sv]
// Package: register map, field positions and reset values of the comparator-one control block
package cmp1_pkg;

	// ********************************************************************
	// Register addresses (special-function space, same on every page)
	// ********************************************************************
	localparam logic [7:0] CMP1_CONTROL_ADDR      = 8'h9A;
	localparam logic [7:0] CMP1_MODE_ADDR         = 8'h9C;
	localparam logic [7:0] CMP1_INPUT_SELECT_ADDR = 8'h9E;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [7:0] CMP1_CONTROL_RESET      = 8'h00;
	localparam logic [7:0] CMP1_MODE_RESET         = 8'h02;
	localparam logic [7:0] CMP1_INPUT_SELECT_RESET = 8'hFF;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int CMP1_POWER_ON_BIT     = 7;
	localparam int CMP1_OUTPUT_STATE_BIT = 6;
	localparam int CMP1_RISE_FLAG_BIT    = 5;
	localparam int CMP1_FALL_FLAG_BIT    = 4;
	localparam int CMP1_HYST_POS_LSB     = 2;
	localparam int CMP1_HYST_NEG_LSB     = 0;
	localparam int CMP1_NEG_SEL_LSB      = 4;
	localparam int CMP1_POS_SEL_LSB      = 0;
	localparam int CMP1_RISE_IE_BIT      = 5;
	localparam int CMP1_FALL_IE_BIT      = 4;
	localparam int CMP1_RESP_LSB         = 0;

	// Fill for unused bit pairs
	localparam logic [1:0] CMP1_SELECT_UNUSED = 2'h3;
	localparam logic [1:0] CMP1_MODE_UNUSED   = 2'h0;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef enum logic [1:0] {
		CMP1_HYST_OFF,
		CMP1_HYST_5MV,
		CMP1_HYST_10MV,
		CMP1_HYST_20MV
	} cmp1_hyst_t;

	typedef enum logic [1:0] {
		CMP1_RESP_100NS,
		CMP1_RESP_175NS,
		CMP1_RESP_320NS,
		CMP1_RESP_1050NS
	} cmp1_resp_t;

	// Settings handed to the analog core and pin multiplexers
	typedef struct packed {
		logic       comparator_power_on;
		cmp1_hyst_t positive_hysteresis_field;
		cmp1_hyst_t negative_hysteresis_field;
		cmp1_resp_t response_time_select;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} cmp1_analog_cfg_t;

	// Processor access to the special-function registers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cmp1_sfr_req_t;

endpackage : cmp1_pkg

// [tb/cmp1_core_model.sv]
// Behavioural model of the analog comparator core behind the control block
`timescale 1ns/100ps
module cmp1_core_model
	import cmp1_pkg::*;
(
	input  wire logic             core_clk_i,
	input  wire cmp1_analog_cfg_t cfg_i,
	input  wire logic             level_i,
	output logic                  raw_o
);
	logic chatter = 1'b0;
	// An unpowered core gives no valid answer, so its line chatters
	always @(posedge core_clk_i) begin
		chatter <= ~chatter;
	end
	assign raw_o = cfg_i.comparator_power_on ? level_i : chatter;
endmodule : cmp1_core_model

// [tb/cmp1_ctrl_sva.sv]
// Assertion checker for the comparator-one control block
`timescale 1ns/100ps
module cmp1_ctrl_sva
	import cmp1_pkg::*;
(
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire cmp1_sfr_req_t    sfr_req_i,
	input  wire logic [7:0]       sfr_rdata_o,
	input  wire logic             sfr_hit_o,
	input  wire logic             comparator_raw_i,
	input  wire cmp1_analog_cfg_t analog_cfg_o,
	input  wire logic             pin_output_o,
	input  wire logic             irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	wire logic pwr = analog_cfg_o.comparator_power_on;
	wire logic rd  = sfr_req_i.rd;
	wire logic wr  = sfr_req_i.wr;

	hit_decode_a: assert property (
		sfr_hit_o == (sfr_req_i.addr inside {8'h9A, 8'h9C, 8'h9E}))
		else $error("address hit flag wrong");
	reset_values_a: assert property ($fell(reset_i) |-> analog_cfg_o == 11'h02F)
		else $error("settings after reset wrong");
	pin_follows_a: assert property (
		(pwr && $stable(comparator_raw_i))[*4] |-> pin_output_o == comparator_raw_i)
		else $error("pin output does not follow comparator");
	pin_low_off_a: assert property ((!pwr)[*2] |-> !pin_output_o)
		else $error("pin output high while disabled");
	ctrl_write_a: assert property (wr && sfr_req_i.addr == 8'h9A |=>
		pwr == $past(sfr_req_i.wdata[7])
		&& {analog_cfg_o.positive_hysteresis_field, analog_cfg_o.negative_hysteresis_field}
		== $past(sfr_req_i.wdata[3:0])) else $error("control write not applied");
	select_fill_a: assert property (rd && sfr_req_i.addr == 8'h9E |=>
		sfr_rdata_o[7:6] == 2'h3 && sfr_rdata_o[3:2] == 2'h3)
		else $error("unused select bits not ones");
	mode_fill_a: assert property (rd && sfr_req_i.addr == 8'h9C |=>
		sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3:2] == 2'h0)
		else $error("unused mode bits not zero");
	unmapped_read_a: assert property (rd && !sfr_hit_o |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	irq_masked_a: assert property (
		wr && sfr_req_i.addr == 8'h9C && sfr_req_i.wdata[5:4] == 2'h0 |=> !irq_o)
		else $error("interrupt with both enables off");
	irq_sticky_a: assert property (irq_o && !wr |=> irq_o)
		else $error("interrupt dropped without a write");
endmodule : cmp1_ctrl_sva

// [tb/tb_cmp1_ctrl.sv]
// Self-checking testbench for the comparator-one control block
`timescale 1ns/100ps
module tb_cmp1_ctrl;
	import cmp1_pkg::*;
	logic             core_clk_i = 1'b0;
	logic             reset_i    = 1'b1;
	cmp1_sfr_req_t    req        = '0;
	logic [7:0]       rdata;
	logic             hit, raw, pin, irq, level = 1'b0, rd_pend = 1'b0;
	cmp1_analog_cfg_t cfg;
	logic [7:0]       exp_q[$];
	logic [7:0]       r;
	int               n_mismatch = 0;
	int               num_checks = 0;

	always #50 core_clk_i = ~core_clk_i;

	cmp1_ctrl dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .sfr_req_i(req),
		.sfr_rdata_o(rdata), .sfr_hit_o(hit), .comparator_raw_i(raw),
		.analog_cfg_o(cfg), .pin_output_o(pin), .irq_o(irq));
	cmp1_core_model core_u (.core_clk_i(core_clk_i), .cfg_i(cfg), .level_i(level), .raw_o(raw));

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge core_clk_i);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
	endtask : access

	task automatic read(input logic [7:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		access(1'b0, a, 8'h00);
	endtask : read

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Read data is registered on the edge that takes the read strobe and checked one edge later
	always @(posedge core_clk_i) begin
		if (rd_pend) check("read data", exp_q.pop_front(), rdata);
		rd_pend <= req.rd;
	end

	initial begin
		#(3000 * 100);
		n_mismatch++;
		report_and_stop();
	end

	// ********************************************************************
	// Tests
	// ********************************************************************
	initial begin
		void'($urandom(32'h155F));
		repeat (20) @(posedge core_clk_i);
		reset_i <= 1'b0;
		read(CMP1_CONTROL_ADDR, 8'h00);
		read(CMP1_MODE_ADDR, 8'h02);
		read(CMP1_INPUT_SELECT_ADDR, 8'hFF);
		read(8'h9B, 8'h00);
		check("hit", 8'h00, {7'h0, hit});
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom);
			access(1'b1, CMP1_CONTROL_ADDR, {4'h4, 2'(i), 2'(3 - i)});
			read(CMP1_CONTROL_ADDR, {4'h0, 2'(i), 2'(3 - i)});
			access(1'b1, CMP1_MODE_ADDR, r);
			read(CMP1_MODE_ADDR, {2'b00, r[5:4], 2'b00, r[1:0]});
			access(1'b1, CMP1_INPUT_SELECT_ADDR, r);
			read(CMP1_INPUT_SELECT_ADDR, {2'b11, r[5:4], 2'b11, r[1:0]});
			check("config", {2'(i), 2'(3 - i), r[1:0], r[1:0]}, {cfg.positive_hysteresis_field,
				cfg.negative_hysteresis_field, cfg.response_time_select,
				cfg.positive_input_select});
			check("neg select", {6'h0, r[5:4]}, {6'h0, cfg.negative_input_select});
			check("hit", 8'h01, {7'h0, hit});
		end
		access(1'b1, CMP1_MODE_ADDR, 8'h32);
		access(1'b1, CMP1_CONTROL_ADDR, 8'h80);
		// Let the chatter of the unpowered core drain out of the synchroniser first
		repeat (3) @(posedge core_clk_i);
		access(1'b1, CMP1_CONTROL_ADDR, 8'h80);
		@(posedge core_clk_i) level <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		@(negedge core_clk_i) check("irq rise", 8'h01, {7'h0, irq});
		check("pin", 8'h01, {7'h0, pin});
		read(CMP1_CONTROL_ADDR, 8'hE0);
		access(1'b1, CMP1_MODE_ADDR, 8'h12);
		@(negedge core_clk_i) check("irq masked", 8'h00, {7'h0, irq});
		@(posedge core_clk_i) level <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		@(negedge core_clk_i) check("irq fall", 8'h01, {7'h0, irq});
		read(CMP1_CONTROL_ADDR, 8'hB0);
		access(1'b1, CMP1_MODE_ADDR, 8'h02);
		@(negedge core_clk_i) check("irq off", 8'h00, {7'h0, irq});
		access(1'b1, CMP1_CONTROL_ADDR, 8'h80);
		read(CMP1_CONTROL_ADDR, 8'h80);
		access(1'b1, CMP1_CONTROL_ADDR, 8'h00);
		repeat (8) @(posedge core_clk_i);
		read(CMP1_CONTROL_ADDR, 8'h00);
		@(negedge core_clk_i) check("pin off", 8'h00, {7'h0, pin});
		repeat (3) @(posedge core_clk_i);
		report_and_stop();
	end
endmodule : tb_cmp1_ctrl

bind cmp1_ctrl cmp1_ctrl_sva chk_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
	.sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
	.comparator_raw_i(comparator_raw_i), .analog_cfg_o(analog_cfg_o),
	.pin_output_o(pin_output_o), .irq_o(irq_o));
